// ### rtl/dual_counter_timer.sv
// Two legacy counter/timers with four modes each, behind an AXI4-Lite slave.
// Assumes one clock; gate inputs are synchronous, count pins are not.
`timescale 1ns/1ps
module dual_counter_timer (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire timer_pkg::axil_req_s axiReq, // AXI4-Lite master signals.
  output timer_pkg::axil_rsp_s axiRsp, // AXI4-Lite slave signals.
  input wire logic zeroCountPin, // External count pin, timer zero.
  input wire logic oneCountPin, // External count pin, timer one.
  input wire logic extClkPin, // External prescaler clock.
  input wire logic zeroGateInput, // Gate input, timer zero.
  input wire logic oneGateInput, // Gate input, timer one.
  input wire logic zeroVectorAck, // Pulse: vectoring to timer zero routine.
  input wire logic oneVectorAck, // Pulse: vectoring to timer one routine.
  output logic zeroIrq, // Timer zero interrupt request.
  output logic oneIrq, // Timer one interrupt request.
  output logic oneOverflowEvent // Pulse: timer one overflow for peripherals.
);
  typedef struct packed {
    timer_pkg::count_s zero;
    timer_pkg::count_s one;
    logic [7:0] control;
    logic [7:0] mode;
    logic [7:0] clock;
    logic [7:0] irqEn;
    logic [7:0] extCfg;
    timer_pkg::axil_rsp_s rsp;
    logic [7:0] awAddr;
    logic [7:0] wData;
    logic wStrb0;
    logic awGot;
    logic wGot;
    timer_pkg::wr_state_e wrState;
    timer_pkg::rd_state_e rdState;
    logic zeroIrq;
    logic oneIrq;
    logic oneOvf;
  } main_state_s;

  main_state_s s_reg;
  main_state_s s_next;
  logic preTick;
  logic zeroFall;
  logic oneFall;
  logic zeroFire;
  logic oneFire;
  logic highFire;
  logic doWrite;
  logic zeroOvf;
  logic highOvf;
  timer_pkg::timer_mode_e zeroMode;
  timer_pkg::timer_mode_e oneMode;

  clock_ticks ticks (
    .clk(clk),
    .rst_n(rst_n),
    .prescaleSel(timer_pkg::prescale_e'(s_reg.clock[timer_pkg::PRESCALE_LSB +: 2])),
    .extClkPin(extClkPin),
    .zeroCountPin(zeroCountPin),
    .oneCountPin(oneCountPin),
    .prescaleTick(preTick),
    .zeroPinFall(zeroFall),
    .onePinFall(oneFall)
  );

  function automatic logic timerTick(logic ct, logic sys, logic pinFall, logic pre);
    timerTick = ct ? pinFall : (sys | pre);
  endfunction

  function automatic logic gateOk(logic run, logic gate, logic gateIn, logic pol);
    gateOk = run & (~gate | (gateIn == pol));
  endfunction

  // Returns overflow and the advanced count for the given mode.
  function automatic logic [16:0] advance(timer_pkg::timer_mode_e m, timer_pkg::count_s c);
    logic [13:0] c13;
    logic [16:0] c16;
    c13 = {1'b0, c.high, c.low[4:0]} + 14'h0001;
    c16 = {1'b0, c} + 17'h00001;
    case (m)
      timer_pkg::MODE_13BIT: advance = {c13[13], c13[12:5], c.low[7:5], c13[4:0]};
      timer_pkg::MODE_16BIT: advance = c16;
      timer_pkg::MODE_RELOAD:
      begin
        if (&c.low)
        begin
          advance = {1'b1, c.high, c.high};
        end
        else
        begin
          advance = {1'b0, c.high, c.low + 8'h01};
        end
      end
      default: advance = {&c.low, c.high, c.low + 8'h01};
    endcase
  endfunction

  function automatic logic [8:0] readReg(main_state_s st, logic [7:0] addr);
    case (addr)
      timer_pkg::ZERO_LOW_OFS: readReg = {1'b1, st.zero.low};
      timer_pkg::ZERO_HIGH_OFS: readReg = {1'b1, st.zero.high};
      timer_pkg::ONE_LOW_OFS: readReg = {1'b1, st.one.low};
      timer_pkg::ONE_HIGH_OFS: readReg = {1'b1, st.one.high};
      timer_pkg::CONTROL_OFS: readReg = {1'b1, st.control};
      timer_pkg::MODE_OFS: readReg = {1'b1, st.mode};
      timer_pkg::CLOCK_OFS: readReg = {1'b1, st.clock};
      timer_pkg::IRQ_EN_OFS: readReg = {1'b1, st.irqEn};
      timer_pkg::EXT_CFG_OFS: readReg = {1'b1, st.extCfg};
      default: readReg = {1'b0, 8'h00};
    endcase
  endfunction

  always_comb
  begin
    logic [16:0] zeroAdv;
    logic [16:0] oneAdv;
    logic [8:0] rd;
    logic [8:0] wr;
    logic split;
    logic oneRun;
    wr = readReg(s_reg, s_reg.awAddr);
    rd = readReg(s_reg, axiReq.araddr);
    zeroMode = timer_pkg::timer_mode_e'(s_reg.mode[timer_pkg::ZERO_MODE_LSB +: 2]);
    oneMode = timer_pkg::timer_mode_e'(s_reg.mode[timer_pkg::ONE_MODE_LSB +: 2]);
    zeroAdv = advance(zeroMode, s_reg.zero);
    oneAdv = advance(oneMode, s_reg.one);
    split = zeroMode == timer_pkg::MODE_SPLIT;
    s_next = s_reg;
    zeroFire = gateOk(s_reg.control[timer_pkg::ZERO_RUN_BIT],
                      s_reg.mode[timer_pkg::ZERO_GATE_BIT], zeroGateInput,
                      s_reg.extCfg[timer_pkg::ZERO_POL_BIT])
      & timerTick(s_reg.mode[timer_pkg::ZERO_CT_BIT], s_reg.clock[timer_pkg::ZERO_SYS_BIT],
                  zeroFall, preTick);
    oneRun = gateOk(s_reg.control[timer_pkg::ONE_RUN_BIT],
                    s_reg.mode[timer_pkg::ONE_GATE_BIT], oneGateInput,
                    s_reg.extCfg[timer_pkg::ONE_POL_BIT]);
    if (split)
    begin
      oneFire = timerTick(1'b0, s_reg.clock[timer_pkg::ONE_SYS_BIT], 1'b0, preTick);
    end
    else
    begin
      oneFire = oneRun & timerTick(s_reg.mode[timer_pkg::ONE_CT_BIT],
                                   s_reg.clock[timer_pkg::ONE_SYS_BIT], oneFall, preTick);
    end
    oneFire = oneFire & (oneMode != timer_pkg::MODE_SPLIT);
    highFire = split & s_reg.control[timer_pkg::ONE_RUN_BIT]
      & timerTick(1'b0, s_reg.clock[timer_pkg::ZERO_SYS_BIT], 1'b0, preTick);
    zeroOvf = zeroFire & zeroAdv[16];
    highOvf = highFire & (&s_reg.zero.high);
    if (zeroFire)
    begin
      s_next.zero = zeroAdv[15:0];
    end
    if (highFire)
    begin
      s_next.zero.high = s_reg.zero.high + 8'h01;
    end
    if (oneFire)
    begin
      s_next.one = oneAdv[15:0];
    end
    s_next.oneOvf = oneFire & oneAdv[16];

    // Write channel: address and data are taken in either order.
    if (axiReq.awvalid && s_reg.rsp.awready)
    begin
      s_next.awAddr = axiReq.awaddr;
      s_next.awGot = 1'b1;
      s_next.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s_reg.rsp.wready)
    begin
      s_next.wData = axiReq.wdata[7:0];
      s_next.wStrb0 = axiReq.wstrb[0];
      s_next.wGot = 1'b1;
      s_next.rsp.wready = 1'b0;
    end
    doWrite = 1'b0;
    case (s_reg.wrState)
      timer_pkg::WR_COLLECT:
      begin
        if (s_reg.awGot && s_reg.wGot)
        begin
          doWrite = 1'b1;
          s_next.awGot = 1'b0;
          s_next.wGot = 1'b0;
          s_next.rsp.bvalid = 1'b1;
          s_next.rsp.bresp = wr[8] ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
          s_next.wrState = timer_pkg::WR_RESP;
        end
      end
      timer_pkg::WR_RESP:
      begin
        if (axiReq.bready)
        begin
          s_next.rsp.bvalid = 1'b0;
          s_next.rsp.awready = 1'b1;
          s_next.rsp.wready = 1'b1;
          s_next.wrState = timer_pkg::WR_COLLECT;
        end
      end
      default: s_next.wrState = timer_pkg::WR_COLLECT;
    endcase
    // A byte write overrides a count step in the same cycle; run never clears the count.
    if (doWrite && s_reg.wStrb0)
    begin
      case (s_reg.awAddr)
        timer_pkg::ZERO_LOW_OFS: s_next.zero.low = s_reg.wData;
        timer_pkg::ZERO_HIGH_OFS: s_next.zero.high = s_reg.wData;
        timer_pkg::ONE_LOW_OFS: s_next.one.low = s_reg.wData;
        timer_pkg::ONE_HIGH_OFS: s_next.one.high = s_reg.wData;
        timer_pkg::CONTROL_OFS: s_next.control = s_reg.wData;
        timer_pkg::MODE_OFS: s_next.mode = s_reg.wData;
        timer_pkg::CLOCK_OFS: s_next.clock = s_reg.wData;
        timer_pkg::IRQ_EN_OFS: s_next.irqEn = s_reg.wData;
        timer_pkg::EXT_CFG_OFS: s_next.extCfg = s_reg.wData;
        default: s_next.control = s_next.control;
      endcase
    end
    if (zeroVectorAck)
    begin
      s_next.control[timer_pkg::ZERO_FLAG_BIT] = 1'b0;
    end
    if (oneVectorAck)
    begin
      s_next.control[timer_pkg::ONE_FLAG_BIT] = 1'b0;
    end
    // Hardware sets come last so an overflow beats a clear in the same cycle.
    if (zeroOvf)
    begin
      s_next.control[timer_pkg::ZERO_FLAG_BIT] = 1'b1;
    end
    if (split ? highOvf : s_next.oneOvf)
    begin
      s_next.control[timer_pkg::ONE_FLAG_BIT] = 1'b1;
    end
    s_next.zeroIrq = s_next.control[timer_pkg::ZERO_FLAG_BIT]
      & s_next.irqEn[timer_pkg::ZERO_IE_BIT];
    s_next.oneIrq = s_next.control[timer_pkg::ONE_FLAG_BIT]
      & s_next.irqEn[timer_pkg::ONE_IE_BIT];

    // Read channel.
    case (s_reg.rdState)
      timer_pkg::RD_IDLE:
      begin
        if (axiReq.arvalid)
        begin
          s_next.rsp.rvalid = 1'b1;
          s_next.rsp.arready = 1'b0;
          s_next.rsp.rdata = {24'h000000, rd[7:0]};
          s_next.rsp.rresp = rd[8] ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
          s_next.rdState = timer_pkg::RD_DATA;
        end
      end
      timer_pkg::RD_DATA:
      begin
        if (axiReq.rready)
        begin
          s_next.rsp.rvalid = 1'b0;
          s_next.rsp.arready = 1'b1;
          s_next.rdState = timer_pkg::RD_IDLE;
        end
      end
      default: s_next.rdState = timer_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.rsp.awready <= 1'b1;
      s_reg.rsp.wready <= 1'b1;
      s_reg.rsp.arready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign axiRsp = s_reg.rsp;
  assign zeroIrq = s_reg.zeroIrq;
  assign oneIrq = s_reg.oneIrq;
  assign oneOverflowEvent = s_reg.oneOvf;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence zeroStepNoWrite;
    zeroFire && !doWrite && !highFire;
  endsequence

  sequence writeBothTaken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence

  chk_mode0_wrap: assert property (
    zeroStepNoWrite and (zeroMode == timer_pkg::MODE_13BIT)
    and (s_reg.zero.high == 8'hFF) and (s_reg.zero.low[4:0] == 5'h1F)
    |=> s_reg.control[timer_pkg::ZERO_FLAG_BIT] && s_reg.zero.high == 8'h00
        && s_reg.zero.low[4:0] == 5'h00)
    else $error("13-bit wrap did not clear count and set flag");

  chk_mode1_wrap: assert property (
    zeroStepNoWrite and (zeroMode == timer_pkg::MODE_16BIT) and (s_reg.zero == 16'hFFFF)
    |=> s_reg.zero == 16'h0000 && s_reg.control[timer_pkg::ZERO_FLAG_BIT])
    else $error("16-bit wrap failed");

  chk_mode2_reload: assert property (
    zeroStepNoWrite and (zeroMode == timer_pkg::MODE_RELOAD) and (s_reg.zero.low == 8'hFF)
    |=> s_reg.zero.low == $past(s_reg.zero.high) && $stable(s_reg.zero.high))
    else $error("Auto-reload did not copy high byte into low byte");

  chk_run_stop: assert property (
    !s_reg.control[timer_pkg::ZERO_RUN_BIT] && !doWrite && !highFire |=> $stable(s_reg.zero))
    else $error("Timer zero counted while stopped");

  chk_one_mode3_hold: assert property (
    oneMode == timer_pkg::MODE_SPLIT && !doWrite |=> $stable(s_reg.one))
    else $error("Timer one counted in mode 3");

  chk_irq_enable: assert property (
    zeroIrq |-> s_reg.irqEn[timer_pkg::ZERO_IE_BIT] && s_reg.control[timer_pkg::ZERO_FLAG_BIT])
    else $error("Interrupt raised while disabled");

  chk_vector_clear: assert property (
    zeroVectorAck && !zeroOvf |=> !s_reg.control[timer_pkg::ZERO_FLAG_BIT] && !zeroIrq)
    else $error("Vector acknowledge did not clear flag");

  chk_split_high: assert property (
    highOvf && !doWrite |=> s_reg.control[timer_pkg::ONE_FLAG_BIT] && s_reg.zero.high == 8'h00)
    else $error("Split high byte wrap did not set timer one flag");

  chk_split_noflag: assert property (
    zeroMode == timer_pkg::MODE_SPLIT && !highOvf && !doWrite
    && !s_reg.control[timer_pkg::ONE_FLAG_BIT] |=> !s_reg.control[timer_pkg::ONE_FLAG_BIT])
    else $error("Timer one set its flag while timer zero is split");

  chk_write_resp: assert property (
    writeBothTaken |=> ##1 axiRsp.bvalid)
    else $error("Write response not given two cycles after address and data");
endmodule

// ### rtl/timer_pkg.sv
// Shared constants and carrier types for the dual counter/timer block.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register master.
package timer_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ZERO_LOW_OFS = 8'h00;
  localparam logic [7:0] ZERO_HIGH_OFS = 8'h04;
  localparam logic [7:0] ONE_LOW_OFS = 8'h08;
  localparam logic [7:0] ONE_HIGH_OFS = 8'h0C;
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] MODE_OFS = 8'h14;
  localparam logic [7:0] CLOCK_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS = 8'h1C;
  localparam logic [7:0] EXT_CFG_OFS = 8'h20;
  localparam int ONE_FLAG_BIT = 7;
  localparam int ONE_RUN_BIT = 6;
  localparam int ZERO_FLAG_BIT = 5;
  localparam int ZERO_RUN_BIT = 4;
  localparam int ONE_GATE_BIT = 7;
  localparam int ONE_CT_BIT = 6;
  localparam int ONE_MODE_LSB = 4;
  localparam int ZERO_GATE_BIT = 3;
  localparam int ZERO_CT_BIT = 2;
  localparam int ZERO_MODE_LSB = 0;
  localparam int ONE_SYS_BIT = 3;
  localparam int ZERO_SYS_BIT = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int ZERO_IE_BIT = 1;
  localparam int ONE_IE_BIT = 3;
  localparam int ZERO_POL_BIT = 3;
  localparam int ONE_POL_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] DIV_BY_12 = 6'h0C;
  localparam logic [5:0] DIV_BY_4 = 6'h04;
  localparam logic [5:0] DIV_BY_48 = 6'h30;
  localparam logic [5:0] EXT_DIV = 6'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } timer_mode_e;

  typedef enum logic [1:0] {
    PRE_DIV12 = 2'h0,
    PRE_DIV4 = 2'h1,
    PRE_DIV48 = 2'h2,
    PRE_EXT8 = 2'h3
  } prescale_e;

  typedef enum logic {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_e;
  typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } count_s;
endpackage

// ### rtl/clock_ticks.sv
// Prescaler and count-pin edge detection for the dual counter/timer.
// Assumes count pins and the external clock are asynchronous levels.
`timescale 1ns/1ps
module clock_ticks (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire timer_pkg::prescale_e prescaleSel, // Shared prescale field.
  input wire logic extClkPin, // External clock for the divide-by-8 choice.
  input wire logic zeroCountPin, // External count pin of timer zero.
  input wire logic oneCountPin, // External count pin of timer one.
  output logic prescaleTick, // One-cycle prescaled tick.
  output logic zeroPinFall, // One-cycle falling edge on timer zero pin.
  output logic onePinFall // One-cycle falling edge on timer one pin.
);
  typedef struct packed {
    logic [5:0] preCnt;
    logic [2:0] extSync;
    logic [2:0] zeroSync;
    logic [2:0] oneSync;
    logic tick;
    logic zeroFall;
    logic oneFall;
  } tick_state_s;

  tick_state_s s_reg;
  tick_state_s s_next;

  function automatic logic [5:0] divisor(timer_pkg::prescale_e sel);
    case (sel)
      timer_pkg::PRE_DIV12: divisor = timer_pkg::DIV_BY_12;
      timer_pkg::PRE_DIV4: divisor = timer_pkg::DIV_BY_4;
      timer_pkg::PRE_DIV48: divisor = timer_pkg::DIV_BY_48;
      default: divisor = timer_pkg::EXT_DIV;
    endcase
  endfunction

  always_comb
  begin
    logic srcEdge;
    srcEdge = 1'b1;
    s_next = s_reg;
    // Bit 0 is the first synchroniser stage; only bit 1 reads it.
    s_next.extSync = {s_reg.extSync[1:0], extClkPin};
    s_next.zeroSync = {s_reg.zeroSync[1:0], zeroCountPin};
    s_next.oneSync = {s_reg.oneSync[1:0], oneCountPin};
    if (prescaleSel == timer_pkg::PRE_EXT8)
    begin
      srcEdge = s_reg.extSync[1] & ~s_reg.extSync[2];
    end
    s_next.tick = 1'b0;
    if (srcEdge)
    begin
      if (s_reg.preCnt >= divisor(prescaleSel) - 6'h01)
      begin
        s_next.preCnt = 6'h00;
        s_next.tick = 1'b1;
      end
      else
      begin
        s_next.preCnt = s_reg.preCnt + 6'h01;
      end
    end
    s_next.zeroFall = ~s_reg.zeroSync[1] & s_reg.zeroSync[2];
    s_next.oneFall = ~s_reg.oneSync[1] & s_reg.oneSync[2];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prescaleTick = s_reg.tick;
  assign zeroPinFall = s_reg.zeroFall;
  assign onePinFall = s_reg.oneFall;
endmodule

// ### testbench/count_pin_model.sv
// Model of the external count pins and the external prescaler clock.
// Assumes pins idle high on pull-ups and are asynchronous to clk.
`timescale 1ns/1ps
module count_pin_model (
  input wire logic clk, // System clock, used only to pace edges.
  output logic zeroCountPin, // Count pin of timer zero.
  output logic oneCountPin, // Count pin of timer one.
  output logic extClkPin // External prescaler clock, held still.
);
  initial
  begin
    zeroCountPin = 1'b1;
    oneCountPin = 1'b1;
    extClkPin = 1'b0;
  end

  // Low and high phases are long enough for the input synchroniser.
  task automatic fall(input logic sel);
    @(posedge clk);
    if (sel)
      oneCountPin <= 1'b0;
    else
      zeroCountPin <= 1'b0;
    repeat (6) @(posedge clk);
    oneCountPin <= 1'b1;
    zeroCountPin <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ### testbench/dual_counter_timer_tb_top.sv
// Self-checking bench for the dual counter/timer over AXI4-Lite.
// Assumes count_pin_model drives the pins; gate inputs come from here.
`timescale 1ns/1ps
module dual_counter_timer_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  timer_pkg::axil_req_s axiReq = '0;
  timer_pkg::axil_rsp_s axiRsp;
  logic zeroCountPin, oneCountPin, extClkPin;
  logic zeroGateInput = 1'b0;
  logic oneGateInput = 1'b0;
  logic zeroVectorAck = 1'b0;
  logic oneVectorAck = 1'b0;
  logic zeroIrq, oneIrq, oneOverflowEvent;
  logic [31:0] rdLast;
  int errTotal = 0;
  int comparisons = 0;
  int oneOvfCount = 0;

  always #4 clk = ~clk;

  // Counts timer one overflow pulses; each pulse stands for one cycle.
  always @(posedge clk)
    if (oneOverflowEvent === 1'b1)
      oneOvfCount <= oneOvfCount + 1;

  dual_counter_timer dual_counter_timer_i (.clk(clk), .rst_n(rst_n), .axiReq(axiReq),
    .axiRsp(axiRsp), .zeroCountPin(zeroCountPin), .oneCountPin(oneCountPin),
    .extClkPin(extClkPin), .zeroGateInput(zeroGateInput), .oneGateInput(oneGateInput),
    .zeroVectorAck(zeroVectorAck), .oneVectorAck(oneVectorAck), .zeroIrq(zeroIrq),
    .oneIrq(oneIrq), .oneOverflowEvent(oneOverflowEvent));

  count_pin_model count_pin_model_i (.clk(clk), .zeroCountPin(zeroCountPin),
    .oneCountPin(oneCountPin), .extClkPin(extClkPin));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk);
      if (axiReq.awvalid && axiRsp.awready === 1'b1)
      begin
        aw = 1'b1;
        axiReq.awvalid <= 1'b0;
      end
      if (axiReq.wvalid && axiRsp.wready === 1'b1)
      begin
        w = 1'b1;
        axiReq.wvalid <= 1'b0;
      end
    end
    while (axiRsp.bvalid !== 1'b1) @(posedge clk);
    axiReq.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    @(posedge clk);
    while (axiRsp.arready !== 1'b1) @(posedge clk);
    axiReq.arvalid <= 1'b0;
    @(posedge clk);
    while (axiRsp.rvalid !== 1'b1) @(posedge clk);
    rdLast = axiRsp.rdata;
    axiReq.rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, axiRsp.rresp});
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, timer_pkg::RESP_OKAY);
    chk(nm, {24'h000000, e}, rdLast);
  endtask

  task automatic falls(input logic sel, input int n);
    repeat (n) count_pin_model_i.fall(sel);
    repeat (6) @(posedge clk);
  endtask

  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    errTotal++;
    giveVerdict();
  end

  initial
  begin
    logic [7:0] addrs [9];
    addrs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (addrs[i]) rc("reset value", addrs[i], timer_pkg::REG_RESET);
    rd(8'h40, timer_pkg::RESP_SLVERR);
    chk("unmapped data", 32'h00000000, rdLast);
    // Mode 1 counting pin falls, wrapping to zero.
    wr(timer_pkg::MODE_OFS, 8'h05);
    wr(timer_pkg::ZERO_LOW_OFS, 8'hFF);
    wr(timer_pkg::ZERO_HIGH_OFS, 8'hFF);
    wr(timer_pkg::IRQ_EN_OFS, 8'h02);
    wr(timer_pkg::CONTROL_OFS, 8'h10);
    rc("zero high kept", timer_pkg::ZERO_HIGH_OFS, 8'hFF);
    falls(1'b0, 1);
    rc("zero low wrap", timer_pkg::ZERO_LOW_OFS, 8'h00);
    rc("zero high wrap", timer_pkg::ZERO_HIGH_OFS, 8'h00);
    rc("zero flag set", timer_pkg::CONTROL_OFS, 8'h30);
    chk("zeroIrq on", 32'h1, {31'h0, zeroIrq});
    @(posedge clk);
    zeroVectorAck <= 1'b1;
    @(posedge clk);
    zeroVectorAck <= 1'b0;
    rc("vector clear", timer_pkg::CONTROL_OFS, 8'h10);
    chk("zeroIrq off", 32'h0, {31'h0, zeroIrq});
    // Gate with both polarities.
    wr(timer_pkg::EXT_CFG_OFS, 8'h08);
    wr(timer_pkg::MODE_OFS, 8'h0D);
    falls(1'b0, 2);
    rc("gate closed high", timer_pkg::ZERO_LOW_OFS, 8'h00);
    zeroGateInput <= 1'b1;
    falls(1'b0, 2);
    rc("gate open high", timer_pkg::ZERO_LOW_OFS, 8'h02);
    wr(timer_pkg::EXT_CFG_OFS, 8'h00);
    falls(1'b0, 1);
    rc("gate closed low", timer_pkg::ZERO_LOW_OFS, 8'h02);
    zeroGateInput <= 1'b0;
    falls(1'b0, 1);
    rc("gate open low", timer_pkg::ZERO_LOW_OFS, 8'h03);
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    falls(1'b0, 1);
    rc("run off", timer_pkg::ZERO_LOW_OFS, 8'h03);
    // Mode 0: 13-bit wrap with the interrupt masked.
    wr(timer_pkg::IRQ_EN_OFS, 8'h00);
    wr(timer_pkg::MODE_OFS, 8'h04);
    wr(timer_pkg::ZERO_LOW_OFS, 8'h1E);
    wr(timer_pkg::ZERO_HIGH_OFS, 8'hFF);
    wr(timer_pkg::CONTROL_OFS, 8'h10);
    falls(1'b0, 2);
    rd(timer_pkg::ZERO_LOW_OFS, timer_pkg::RESP_OKAY);
    chk("13-bit low", 32'h00000000, rdLast & 32'h0000001F);
    rc("13-bit high", timer_pkg::ZERO_HIGH_OFS, 8'h00);
    rc("13-bit flag", timer_pkg::CONTROL_OFS, 8'h30);
    chk("zeroIrq masked", 32'h0, {31'h0, zeroIrq});
    // Mode 2 on timer one; software preloads the low byte.
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    wr(timer_pkg::MODE_OFS, 8'h60);
    wr(timer_pkg::ONE_LOW_OFS, 8'hFE);
    wr(timer_pkg::ONE_HIGH_OFS, 8'hF0);
    wr(timer_pkg::IRQ_EN_OFS, 8'h08);
    wr(timer_pkg::CONTROL_OFS, 8'h40);
    falls(1'b1, 3);
    rc("reload low", timer_pkg::ONE_LOW_OFS, 8'hF1);
    rc("reload high", timer_pkg::ONE_HIGH_OFS, 8'hF0);
    rc("one flag", timer_pkg::CONTROL_OFS, 8'hC0);
    chk("oneIrq on", 32'h1, {31'h0, oneIrq});
    chk("one overflow event", 32'h1, oneOvfCount);
    // Timer one in mode 3 is held still.
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    wr(timer_pkg::MODE_OFS, 8'h70);
    wr(timer_pkg::ONE_LOW_OFS, 8'h05);
    wr(timer_pkg::CONTROL_OFS, 8'h40);
    falls(1'b1, 2);
    rc("one mode 3", timer_pkg::ONE_LOW_OFS, 8'h05);
    // Timer zero split: low byte counts pins, high byte waits for one run.
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    wr(timer_pkg::MODE_OFS, 8'h77);
    wr(timer_pkg::ZERO_LOW_OFS, 8'h10);
    wr(timer_pkg::ZERO_HIGH_OFS, 8'h20);
    wr(timer_pkg::CONTROL_OFS, 8'h10);
    falls(1'b0, 2);
    rc("split low", timer_pkg::ZERO_LOW_OFS, 8'h12);
    rc("split high", timer_pkg::ZERO_HIGH_OFS, 8'h20);
    rc("two modes", timer_pkg::MODE_OFS, 8'h77);
    // Split high byte, run by timer one's bit on the /12 clock, sets timer one's flag.
    wr(timer_pkg::ZERO_HIGH_OFS, 8'hFF);
    wr(timer_pkg::CONTROL_OFS, 8'h50);
    repeat (16) @(posedge clk);
    rc("split one flag", timer_pkg::CONTROL_OFS, 8'hD0);
    chk("split oneIrq", 32'h1, {31'h0, oneIrq});
    oneVectorAck <= 1'b1;
    @(posedge clk);
    oneVectorAck <= 1'b0;
    rc("one vector clear", timer_pkg::CONTROL_OFS, 8'h50);
    chk("oneIrq off", 32'h0, {31'h0, oneIrq});
    chk("no mode 3 event", 32'h1, oneOvfCount);
    // Timer zero in mode 2 on the system clock reloads from the high byte.
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    wr(timer_pkg::MODE_OFS, 8'h02);
    wr(timer_pkg::CLOCK_OFS, 8'h04);
    wr(timer_pkg::ZERO_HIGH_OFS, 8'hF0);
    wr(timer_pkg::ZERO_LOW_OFS, 8'hF0);
    wr(timer_pkg::CONTROL_OFS, 8'h10);
    repeat (20) @(posedge clk);
    rc("sysclk reload flag", timer_pkg::CONTROL_OFS, 8'h30);
    wr(timer_pkg::CONTROL_OFS, 8'h00);
    rd(timer_pkg::ZERO_LOW_OFS, timer_pkg::RESP_OKAY);
    chk("reload range", 32'h000000F0, rdLast & 32'h000000F0);
    rc("reload keeps high", timer_pkg::ZERO_HIGH_OFS, 8'hF0);
    giveVerdict();
  end
endmodule
